//--- hdl/acjc_top.sv
// Contract
// - With the alarm-source bit set, the loss pin is high only while line signal is lost.
// - With the alarm-source bit clear, the loss pin is high on signal loss or lost frame sync.
// - With the test-sequence bit set, per-slot test bytes are the a-law milliwatt pattern.
// - With the test-sequence bit clear, per-slot test bytes come from a 2^15-1 prbs.
// - Writing the test-sequence bit as one restarts the prbs generator.
// - The frame-pulse format bit picks the alternate pulse polarity when set, default when clear.
// - The attenuator select bit bypasses the attenuator when clear and inserts it when set.
// - The direction bit puts the attenuator on transmit data when set, receive data when clear.
// - Each toggle of the centre bit recentres the attenuator fifo read pointer, except while the clear bit is set.
// - The depth field sets the fifo depth to 16 times the field plus one words.
// - While the clear bit is set, attenuator pointers and status reset and it reads empty.
// - Clearing the attenuator does not zero the stored data words.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module acjc_top (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	// register port
	input  wire logic [acjc_pkg::ADDR_W-1:0]   reg_addr,
	input  wire logic [acjc_pkg::DATA_W-1:0]   reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [acjc_pkg::DATA_W-1:0]   reg_rdata,
	output logic                               irq,
	// alarm
	input  wire logic                          line_signal_lost_status,
	input  wire logic                          frame_sync_status,
	output logic                               loss_indication_pin,
	// per-slot test sequence
	input  wire logic                          test_byte_req,
	output logic      [7:0]                    test_byte,
	// backplane frame pulse
	input  wire logic                          fp_drive_en,
	input  wire logic                          fp_tx_start,
	input  wire logic                          backplane_frame_pulse_pin_i,
	output logic                               backplane_frame_pulse_pin_o,
	output logic                               backplane_frame_pulse_pin_oe,
	output logic                               fp_rx_start,
	// line data paths
	input  wire logic                          tx_in_data,
	input  wire logic                          tx_in_valid,
	output logic                               tx_out_data,
	input  wire logic                          rx_in_data,
	input  wire logic                          rx_in_valid,
	output logic                               rx_out_data
);
	import acjc_pkg::*;

	logic [7:0]          acw_reg;
	logic [7:0]          jac_reg;
	logic                ctr_prev_reg;
	logic [IRQ_W-1:0]    irq_stat_reg;
	logic [IRQ_W-1:0]    irq_en_reg;
	logic [IRQ_W-1:0]    irq_events;
	logic [IRQ_W-1:0]    irq_clr;
	logic                loss_next;
	logic [14:0]         prbs_reg;
	logic [14:0]         prbs_next;
	logic [2:0]          mw_idx_reg;
	logic                fp_s1_reg;
	logic                fp_s2_reg;
	logic                fp_s3_reg;
	logic [BIT_DIV_W-1:0] div_reg;
	logic                bit_tick;
	logic                tx_last_reg;
	logic                rx_last_reg;
	logic                ja_en;
	logic                ja_tx;
	logic                ja_rx;
	logic                centre_pulse;
	logic                wr_hit_acw;
	logic                wr_hit_jac;

	acjc_ja_if ja ();

	acjc_ja_fifo u_fifo (
		.clk   (clk),
		.rst_n (rst_n),
		.ja    (ja.fifo)
	);

	// ************************************************
	// control registers
	// ************************************************
	assign wr_hit_acw = reg_wr && (reg_addr == ACW_ADDR);
	assign wr_hit_jac = reg_wr && (reg_addr == JAC_ADDR);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acw_reg <= ACW_RESET;
			jac_reg <= JAC_RESET;
		end else begin
			if (wr_hit_acw) begin
				acw_reg <= reg_wdata & ACW_MASK;
			end
			if (wr_hit_jac) begin
				jac_reg <= reg_wdata & JAC_MASK;
			end
		end
	end

	// either direction of change counts as one centring request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctr_prev_reg <= 1'b0;
		end else begin
			ctr_prev_reg <= jac_reg[JAC_CTR_BIT];
		end
	end
	assign centre_pulse = jac_reg[JAC_CTR_BIT] ^ ctr_prev_reg;

	// read data stands one cycle after the strobe only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= READ_ZERO;
		end else if (reg_rd) begin
			unique case (reg_addr)
				ACW_ADDR:      reg_rdata <= acw_reg;
				JAC_ADDR:      reg_rdata <= jac_reg;
				IRQ_STAT_ADDR: reg_rdata <= 8'(irq_stat_reg);
				IRQ_EN_ADDR:   reg_rdata <= 8'(irq_en_reg);
				JA_STAT_ADDR:  reg_rdata <= {6'h00, ja.full, ja.empty};
				default:       reg_rdata <= READ_ZERO;
			endcase
		end else begin
			reg_rdata <= READ_ZERO;
		end
	end

	// ************************************************
	// interrupts
	// ************************************************
	assign irq_events[IRQ_LOSS_BIT] = loss_next && !loss_indication_pin;
	assign irq_events[IRQ_OVF_BIT]  = ja.overflow;
	assign irq_events[IRQ_UNF_BIT]  = ja.underflow;
	assign irq_events[IRQ_CTR_BIT]  = centre_pulse;
	assign irq_clr = (reg_wr && reg_addr == IRQ_CLR_ADDR) ? reg_wdata[IRQ_W-1:0] : IRQ_RESET;

	// a new event beats a clear in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_reg <= IRQ_RESET;
			irq_en_reg   <= IRQ_RESET;
			irq          <= 1'b0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_events;
			if (reg_wr && reg_addr == IRQ_EN_ADDR) begin
				irq_en_reg <= reg_wdata[IRQ_W-1:0];
			end
			irq <= |(((irq_stat_reg & ~irq_clr) | irq_events) & irq_en_reg);
		end
	end

	// ************************************************
	// loss indication
	// ************************************************
	always_comb begin
		if (acw_reg[ACW_LOS_ONLY_BIT]) begin
			loss_next = line_signal_lost_status;
		end else begin
			loss_next = line_signal_lost_status || !frame_sync_status;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			loss_indication_pin <= 1'b0;
		end else begin
			loss_indication_pin <= loss_next;
		end
	end

	// ************************************************
	// test sequence
	// ************************************************
	assign prbs_next = prbs_step8(prbs_reg);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prbs_reg   <= PRBS_SEED;
			mw_idx_reg <= 3'h0;
			test_byte  <= 8'h00;
		end else if (wr_hit_acw && reg_wdata[ACW_MW_BIT]) begin
			prbs_reg   <= PRBS_SEED;
			mw_idx_reg <= 3'h0;
		end else if (test_byte_req) begin
			if (acw_reg[ACW_MW_BIT]) begin
				test_byte  <= mw_byte(mw_idx_reg);
				mw_idx_reg <= mw_idx_reg + 3'h1;
			end else begin
				prbs_reg  <= prbs_next;
				test_byte <= prbs_next[7:0];
			end
		end
	end

	// ************************************************
	// backplane frame pulse
	// ************************************************
	// default format is active low, alternate format active high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			backplane_frame_pulse_pin_o  <= 1'b1;
			backplane_frame_pulse_pin_oe <= 1'b0;
		end else begin
			backplane_frame_pulse_pin_o  <= acw_reg[ACW_GCI_BIT] ? fp_tx_start : !fp_tx_start;
			backplane_frame_pulse_pin_oe <= fp_drive_en;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fp_s1_reg   <= 1'b1;
			fp_s2_reg   <= 1'b1;
			fp_s3_reg   <= 1'b1;
			fp_rx_start <= 1'b0;
		end else begin
			fp_s1_reg   <= backplane_frame_pulse_pin_i;
			fp_s2_reg   <= fp_s1_reg;
			fp_s3_reg   <= fp_s2_reg;
			fp_rx_start <= !fp_drive_en && (acw_reg[ACW_GCI_BIT] ? (fp_s2_reg && !fp_s3_reg)
				: (!fp_s2_reg && fp_s3_reg));
		end
	end

	// ************************************************
	// jitter attenuator path
	// ************************************************
	assign ja_en = jac_reg[JAC_SEL_BIT];
	assign ja_tx = ja_en && jac_reg[JAC_DIR_BIT];
	assign ja_rx = ja_en && !jac_reg[JAC_DIR_BIT];
	assign bit_tick = (div_reg == BIT_DIV - 1'b1);

	assign ja.depth_code = jac_reg[JAC_DEPTH_MSB:JAC_DEPTH_LSB];
	assign ja.clear      = jac_reg[JAC_CLR_BIT];
	assign ja.centre     = centre_pulse;
	assign ja.wr_valid   = (ja_tx && tx_in_valid) || (ja_rx && rx_in_valid);
	assign ja.wr_data    = ja_tx ? tx_in_data : rx_in_data;
	assign ja.rd_en      = ja_en && bit_tick;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= '0;
		end else begin
			div_reg <= bit_tick ? '0 : div_reg + 1'b1;
		end
	end

	// output words lag the fifo read by one bit slot
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_last_reg <= 1'b0;
			rx_last_reg <= 1'b0;
			tx_out_data <= 1'b0;
			rx_out_data <= 1'b0;
		end else begin
			if (tx_in_valid) begin
				tx_last_reg <= tx_in_data;
			end
			if (rx_in_valid) begin
				rx_last_reg <= rx_in_data;
			end
			if (bit_tick) begin
				tx_out_data <= ja_tx ? ja.rd_data : tx_last_reg;
				rx_out_data <= ja_rx ? ja.rd_data : rx_last_reg;
			end
		end
	end

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_los_only;
		acw_reg[ACW_LOS_ONLY_BIT] && !line_signal_lost_status |=> !loss_indication_pin;
	endproperty
	a_los_only: assert property (p_los_only) else $error("loss pin high without signal loss");

	property p_los_or_lof;
		!acw_reg[ACW_LOS_ONLY_BIT] && !frame_sync_status |=> loss_indication_pin;
	endproperty
	a_los_or_lof: assert property (p_los_or_lof) else $error("loss pin low on frame loss");

	property p_mw_first;
		acw_reg[ACW_MW_BIT] && test_byte_req && mw_idx_reg == 3'h0 && !wr_hit_acw |=> test_byte == 8'h34;
	endproperty
	a_mw_first: assert property (p_mw_first) else $error("milliwatt pattern wrong");

	property p_prbs_live;
		prbs_reg != 15'h0000;
	endproperty
	a_prbs_live: assert property (p_prbs_live) else $error("prbs locked at zero");

	sequence s_seq_write;
		wr_hit_acw && reg_wdata[ACW_MW_BIT];
	endsequence
	property p_prbs_restart;
		s_seq_write |=> prbs_reg == PRBS_SEED ##1 (test_byte_req || prbs_reg == PRBS_SEED);
	endproperty
	a_prbs_restart: assert property (p_prbs_restart) else $error("prbs not restarted");

	property p_fp_default;
		!acw_reg[ACW_GCI_BIT] && fp_tx_start |=> !backplane_frame_pulse_pin_o;
	endproperty
	a_fp_default: assert property (p_fp_default) else $error("frame pulse polarity wrong");

	property p_bypass;
		!jac_reg[JAC_SEL_BIT] |-> !ja.wr_valid && !ja.rd_en;
	endproperty
	a_bypass: assert property (p_bypass) else $error("attenuator active while disabled");

	property p_tx_side;
		ja_en && jac_reg[JAC_DIR_BIT] && tx_in_valid |-> ja.wr_valid && ja.wr_data == tx_in_data;
	endproperty
	a_tx_side: assert property (p_tx_side) else $error("transmit data not fed to attenuator");

	sequence s_centre_toggle;
		wr_hit_jac && reg_wdata[JAC_CTR_BIT] != jac_reg[JAC_CTR_BIT] && !reg_wdata[JAC_CLR_BIT];
	endsequence
	property p_centre;
		s_centre_toggle |=> ja.centre ##1 (!ja.centre || $changed(jac_reg[JAC_CTR_BIT]));
	endproperty
	a_centre: assert property (p_centre) else $error("centre toggle missed");
endmodule
`default_nettype wire

//--- hdl/acjc_pkg.sv
package acjc_pkg;
	// ************************************************
	// register map
	// ************************************************
	localparam int          ADDR_W        = 5;
	localparam int          DATA_W        = 8;
	localparam logic [4:0]  ACW_ADDR      = 5'h13;
	localparam logic [4:0]  JAC_ADDR      = 5'h18;
	localparam logic [4:0]  IRQ_STAT_ADDR = 5'h04;
	localparam logic [4:0]  IRQ_CLR_ADDR  = 5'h05;
	localparam logic [4:0]  IRQ_EN_ADDR   = 5'h06;
	localparam logic [4:0]  JA_STAT_ADDR  = 5'h07;
	localparam logic [7:0]  ACW_RESET     = 8'h00;
	localparam logic [7:0]  JAC_RESET     = 8'h00;
	localparam logic [7:0]  ACW_MASK      = 8'h07;
	localparam logic [7:0]  JAC_MASK      = 8'hFE;
	localparam logic [7:0]  READ_ZERO     = 8'h00;

	// ************************************************
	// field positions
	// ************************************************
	localparam int ACW_LOS_ONLY_BIT = 2;
	localparam int ACW_MW_BIT       = 1;
	localparam int ACW_GCI_BIT      = 0;
	localparam int JAC_SEL_BIT      = 7;
	localparam int JAC_DIR_BIT      = 6;
	localparam int JAC_CTR_BIT      = 5;
	localparam int JAC_DEPTH_MSB    = 4;
	localparam int JAC_DEPTH_LSB    = 2;
	localparam int JAC_CLR_BIT      = 1;
	localparam int IRQ_W            = 4;
	localparam int IRQ_LOSS_BIT     = 0;
	localparam int IRQ_OVF_BIT      = 1;
	localparam int IRQ_UNF_BIT      = 2;
	localparam int IRQ_CTR_BIT      = 3;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

	// ************************************************
	// attenuator fifo and line timing
	// ************************************************
	localparam int         JA_AW     = 7;
	localparam int         JA_SLOTS  = 128;
	localparam logic [7:0] JA_STEP   = 8'h10;
	localparam int         CLK_FREQ_KHZ  = 125000;
	localparam int         LINE_RATE_KHZ = 2048;
	localparam int         BIT_DIV_W     = 6;
	localparam logic [BIT_DIV_W-1:0] BIT_DIV = BIT_DIV_W'(CLK_FREQ_KHZ / LINE_RATE_KHZ);

	// ************************************************
	// test sequences
	// ************************************************
	localparam int             PRBS_LEN  = 15;
	localparam logic [14:0]    PRBS_SEED = 15'h7FFF;

	function automatic logic [7:0] ja_depth(input logic [2:0] code);
		ja_depth = JA_STEP * (8'(code) + 8'h01);
	endfunction

	function automatic logic [14:0] prbs_step8(input logic [14:0] s);
		logic [14:0] t;
		t = s;
		for (int i = 0; i < 8; i++) begin
			t = {t[13:0], t[14] ^ t[13]};
		end
		prbs_step8 = t;
	endfunction

	// a-law digital milliwatt, eight bytes per cycle
	function automatic logic [7:0] mw_byte(input logic [2:0] idx);
		unique case (idx)
			3'h0, 3'h3: mw_byte = 8'h34;
			3'h1, 3'h2: mw_byte = 8'h21;
			3'h4, 3'h7: mw_byte = 8'hB4;
			3'h5, 3'h6: mw_byte = 8'hA1;
		endcase
	endfunction
endpackage

//--- hdl/acjc_ja_if.sv
`timescale 1ns/1ps
`default_nettype none
interface acjc_ja_if;
	logic [2:0] depth_code;
	logic       clear;
	logic       centre;
	logic       wr_valid;
	logic       wr_data;
	logic       rd_en;
	logic       rd_data;
	logic       empty;
	logic       full;
	logic       overflow;
	logic       underflow;
	logic [7:0] count;
	modport fifo (input depth_code, clear, centre, wr_valid, wr_data, rd_en,
		output rd_data, empty, full, overflow, underflow, count);
	modport ctrl (output depth_code, clear, centre, wr_valid, wr_data, rd_en,
		input rd_data, empty, full, overflow, underflow, count);
endinterface
`default_nettype wire

//--- hdl/acjc_ja_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module acjc_ja_fifo (
	// clock and reset
	input wire logic   clk,
	input wire logic   rst_n,
	// control side
	acjc_ja_if.fifo    ja
);
	import acjc_pkg::*;

	logic [JA_SLOTS-1:0] mem_reg;
	logic [JA_AW-1:0]    wr_ptr_reg;
	logic [JA_AW-1:0]    rd_ptr_reg;
	logic [7:0]          count_reg;
	logic [7:0]          depth;
	logic [7:0]          half;
	logic                wr_ok;
	logic                rd_ok;

	assign depth = ja_depth(ja.depth_code);
	assign half  = depth >> 1;
	assign wr_ok = ja.wr_valid && (count_reg < depth) && !ja.clear;
	assign rd_ok = ja.rd_en && (count_reg != 8'h00) && !ja.clear && !ja.centre;
	assign ja.empty = (count_reg == 8'h00);
	assign ja.full  = (count_reg >= depth);
	assign ja.count = count_reg;

	// ************************************************
	// storage
	// ************************************************
	// no reset on the words: clearing touches control only
	always_ff @(posedge clk) begin
		if (wr_ok) begin
			mem_reg[wr_ptr_reg] <= ja.wr_data;
		end
	end

	// ************************************************
	// pointers
	// ************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= 8'h00;
		end else if (ja.clear) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= 8'h00;
		end else if (ja.centre) begin
			wr_ptr_reg <= wr_ptr_reg + JA_AW'(wr_ok);
			rd_ptr_reg <= wr_ptr_reg + JA_AW'(wr_ok) - half[JA_AW-1:0];
			count_reg  <= half;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + JA_AW'(wr_ok);
			rd_ptr_reg <= rd_ptr_reg + JA_AW'(rd_ok);
			count_reg  <= count_reg + 8'(wr_ok) - 8'(rd_ok);
		end
	end

	// ************************************************
	// read data and error pulses
	// ************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ja.rd_data   <= 1'b0;
			ja.overflow  <= 1'b0;
			ja.underflow <= 1'b0;
		end else begin
			if (rd_ok) begin
				ja.rd_data <= mem_reg[rd_ptr_reg];
			end
			ja.overflow  <= ja.wr_valid && !wr_ok && !ja.clear;
			ja.underflow <= ja.rd_en && (count_reg == 8'h00) && !ja.clear && !ja.centre;
		end
	end

	// ************************************************
	// checks
	// ************************************************
	property p_depth_bound;
		@(posedge clk) disable iff (!rst_n) ja.full |=> count_reg <= $past(count_reg);
	endproperty
	a_depth_bound: assert property (p_depth_bound) else $error("fifo grew past depth");

	property p_clear_empty;
		@(posedge clk) disable iff (!rst_n) ja.clear |=> ja.empty && !ja.full;
	endproperty
	a_clear_empty: assert property (p_clear_empty) else $error("fifo not empty after clear");
endmodule
`default_nettype wire

//--- dv/acjc_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************
// line and backplane side of the block
// ************************************************
module acjc_line_model (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// commands from the bench
	input  wire logic want_lost,
	input  wire logic want_sync,
	input  wire logic want_pulse,
	input  wire logic alt_format,
	// line status and frame pulse pin
	output logic      line_lost,
	output logic      frame_sync,
	output logic      fp_pin
);
	// status moves only on edges, like a settled line detector
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			line_lost <= 1'b0;
			frame_sync <= 1'b1;
		end else begin
			line_lost <= want_lost;
			frame_sync <= want_sync;
		end
	end

	// pin rests at its inactive level, one-cycle pulse at the active level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fp_pin <= 1'b1;
		end else begin
			fp_pin <= want_pulse ? alt_format : !alt_format;
		end
	end
endmodule
`default_nettype wire

//--- dv/acjc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module acjc_top_bench;
	import acjc_pkg::*;
	logic       clk, rst_n, reg_wr, reg_rd, test_byte_req, fp_drive_en, fp_tx_start;
	logic       tx_in_data, tx_in_valid, rx_in_data, rx_in_valid;
	logic       want_lost, want_sync, want_pulse, alt_format;
	logic       line_lost, frame_sync, fp_pin;
	logic       irq, loss_pin, fp_o, fp_oe, fp_rx_start, tx_out_data, rx_out_data;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, test_byte;
	int         mismatches, num_checks;

	// ************************************************
	// clock, model and design
	// ************************************************
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	acjc_line_model u_far (.clk(clk), .rst_n(rst_n), .want_lost(want_lost), .want_sync(want_sync),
		.want_pulse(want_pulse), .alt_format(alt_format), .line_lost(line_lost),
		.frame_sync(frame_sync), .fp_pin(fp_pin));

	acjc_top DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .line_signal_lost_status(line_lost),
		.frame_sync_status(frame_sync), .loss_indication_pin(loss_pin), .test_byte_req(test_byte_req),
		.test_byte(test_byte), .fp_drive_en(fp_drive_en), .fp_tx_start(fp_tx_start),
		.backplane_frame_pulse_pin_i(fp_pin), .backplane_frame_pulse_pin_o(fp_o),
		.backplane_frame_pulse_pin_oe(fp_oe), .fp_rx_start(fp_rx_start), .tx_in_data(tx_in_data),
		.tx_in_valid(tx_in_valid), .tx_out_data(tx_out_data), .rx_in_data(rx_in_data),
		.rx_in_valid(rx_in_valid), .rx_out_data(rx_out_data));

	// ************************************************
	// shared tasks
	// ************************************************
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// masked compare, so live status bits do not disturb the one under test
	task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk("read data", e, reg_rdata & m);
	endtask

	task automatic tbyte(input logic [7:0] e);
		@(posedge clk);
		test_byte_req <= 1'b1;
		@(posedge clk);
		test_byte_req <= 1'b0;
		#1 chk("test byte", e, test_byte);
	endtask

	function automatic logic [14:0] nxt8(input logic [14:0] s);
		for (int i = 0; i < 8; i++) begin
			s = {s[13:0], s[14] ^ s[13]};
		end
		return s;
	endfunction

	// one bit in, then two line ticks so any fifo lag has passed
	task automatic line(input logic tx, input logic v);
		@(posedge clk);
		if (tx) begin
			tx_in_data <= v;
			tx_in_valid <= 1'b1;
		end else begin
			rx_in_data <= v;
			rx_in_valid <= 1'b1;
		end
		@(posedge clk);
		tx_in_valid <= 1'b0;
		rx_in_valid <= 1'b0;
		repeat (130) @(posedge clk);
		#1 chk(tx ? "tx out" : "rx out", v, tx ? tx_out_data : rx_out_data);
	endtask

	// ************************************************
	// scenarios
	// ************************************************
	task automatic t_regs;
		rd(ACW_ADDR, 8'h00, 8'hFF);
		rd(JAC_ADDR, 8'h00, 8'hFF);
		rd(5'h11, 8'h00, 8'hFF);
		rd(IRQ_CLR_ADDR, 8'h00, 8'hFF);
		wr(ACW_ADDR, 8'hFF);
		rd(ACW_ADDR, 8'h07, 8'hFF);
		wr(JAC_ADDR, 8'h5C);
		rd(JAC_ADDR, 8'h5C, 8'hFF);
		wr(JAC_ADDR, 8'h00);
	endtask

	task automatic t_loss;
		for (int m = 0; m < 2; m++) begin
			wr(ACW_ADDR, {5'h00, m[0], 2'b00});
			for (int k = 0; k < 4; k++) begin
				want_lost <= k[0];
				want_sync <= k[1];
				repeat (4) @(posedge clk);
				#1 chk("loss pin", m[0] ? k[0] : (k[0] | !k[1]), loss_pin);
			end
		end
	endtask

	task automatic t_seq;
		logic [14:0] s;
		logic [7:0]  mw [8];
		mw = '{8'h34, 8'h21, 8'h21, 8'h34, 8'hB4, 8'hA1, 8'hA1, 8'hB4};
		wr(ACW_ADDR, 8'h02);
		for (int i = 0; i < 9; i++) begin
			tbyte(mw[i % 8]);
		end
		for (int r = 0; r < 2; r++) begin
			wr(ACW_ADDR, 8'h02);
			wr(ACW_ADDR, 8'h00);
			s = 15'h7FFF;
			for (int i = 0; i < 3 - 2 * r; i++) begin
				s = nxt8(s);
				tbyte(s[7:0]);
			end
		end
	endtask

	task automatic t_fp;
		logic seen;
		for (int f = 0; f < 2; f++) begin
			@(posedge clk);
			alt_format <= f[0];
			fp_drive_en <= 1'b1;
			wr(ACW_ADDR, {7'h00, f[0]});
			repeat (3) @(posedge clk);
			#1 chk("pulse idle", !f[0], fp_o);
			@(posedge clk);
			fp_tx_start <= 1'b1;
			@(posedge clk);
			fp_tx_start <= 1'b0;
			#1 chk("pulse active", f[0], fp_o);
			chk("pulse enable", 1'b1, fp_oe);
			@(posedge clk);
			fp_drive_en <= 1'b0;
			repeat (5) @(posedge clk);
			want_pulse <= 1'b1;
			@(posedge clk);
			want_pulse <= 1'b0;
			seen = 1'b0;
			repeat (8) begin
				@(posedge clk);
				#1 if (fp_rx_start === 1'b1) seen = 1'b1;
			end
			chk("pulse received", 1'b1, seen);
		end
	endtask

	task automatic t_path;
		logic [7:0] cfg [3];
		cfg = '{8'h00, 8'h80, 8'hC0};
		for (int c = 0; c < 3; c++) begin
			wr(JAC_ADDR, cfg[c]);
			for (int v = 1; v >= 0; v--) begin
				line(1'b1, v[0]);
				line(1'b0, v[0]);
			end
		end
	endtask

	// centring leaves half the depth; tick reads drain it, the next read underflows
	task automatic t_ja;
		logic [2:0] cc;
		int         h;
		wr(IRQ_EN_ADDR, 8'h04);
		for (int c = 0; c < 8; c++) begin
			cc = c[2:0];
			h = 8 * (c + 1);
			wr(JAC_ADDR, {2'b11, ~cc[0], cc, 2'b00});
			wr(IRQ_CLR_ADDR, 8'h0F);
			repeat (h * 61 - 14) @(posedge clk);
			rd(IRQ_STAT_ADDR, 8'h00, 8'h04);
			repeat (122) @(posedge clk);
			rd(IRQ_STAT_ADDR, 8'h04, 8'h04);
			chk("irq", 1'b1, irq);
		end
		wr(JAC_ADDR, 8'hC2);
		wr(IRQ_EN_ADDR, 8'h00);
		repeat (2) @(posedge clk);
		#1 chk("irq masked", 1'b0, irq);
		wr(IRQ_EN_ADDR, 8'h04);
		repeat (2) @(posedge clk);
		#1 chk("irq enabled", 1'b1, irq);
		wr(IRQ_CLR_ADDR, 8'h04);
		repeat (2) @(posedge clk);
		#1 chk("irq cleared", 1'b0, irq);
		rd(IRQ_STAT_ADDR, 8'h00, 8'h04);
		wr(JAC_ADDR, 8'hFC);
		rd(JA_STAT_ADDR, 8'h00, 8'h01);
		wr(JAC_ADDR, 8'hFE);
		rd(JA_STAT_ADDR, 8'h01, 8'h03);
		// refill past the depth; writes beyond it are refused and flagged
		wr(JAC_ADDR, 8'hC0);
		wr(IRQ_CLR_ADDR, 8'h0F);
		@(posedge clk);
		tx_in_valid <= 1'b1;
		repeat (20) @(posedge clk);
		tx_in_valid <= 1'b0;
		rd(IRQ_STAT_ADDR, 8'h02, 8'h02);
	endtask

	// ************************************************
	// run control
	// ************************************************
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// tests need about 20000 cycles; twice that means a hang
	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		summarize();
	end

	initial begin
		{rst_n, reg_wr, reg_rd, test_byte_req, fp_drive_en, fp_tx_start} = '0;
		{tx_in_data, tx_in_valid, rx_in_data, rx_in_valid} = '0;
		{want_lost, want_pulse, alt_format} = '0;
		want_sync = 1'b1;
		reg_addr = '0;
		reg_wdata = '0;
		mismatches = 0;
		num_checks = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_loss();
		t_seq();
		t_fp();
		t_path();
		t_ja();
		summarize();
	end
endmodule
`default_nettype wire
